// *** hdl/clk_cfg_top.sv ***
// configuration registers, serial slave and output control of the clock synthesizer
//
// Operation
// - mode 00, pin low: outputs forced inactive
// - mode 01, pin low: outputs high impedance
// - mode 11: pin is slave address bit one
// - new address bit applies from next transfer
// - select bit picks first or second input
// - select bit ignored for crystal or differential
// - source field: crystal, LVCMOS, differential, reserved
// - power down tri-states outputs, keeps registers
// - power down beats pin force or tri-state
// - post-dividers divide 1..127, zero disallowed
// - output select picks divider zero to five
`timescale 1ns/100ps
`default_nettype none
`include "clk_cfg_map.svh"

module clk_cfg_top
    import clk_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic SECOND_CONTROL_PIN_I,
    input wire logic FIRST_CLOCK_INPUT_I,
    input wire logic SECOND_CLOCK_INPUT_I,
    output logic [`NUM_OUT-1:0] CLOCK_OUTPUT_O,
    output logic [`NUM_OUT-1:0] CLOCK_OUTPUT_OE_O,
    output logic [1:0] INPUT_SOURCE_O,
    output logic POWER_DOWN_O
);

    // ----------------------------------------
    // reset image
    // ----------------------------------------
    localparam logic [`NUM_REGS-1:0][7:0] REG_RST = {
        {6{`RST_OUT_CFG}},
        {1'b0, `RST_DIV5}, {1'b0, `RST_DIV4}, {1'b0, `RST_DIV3},
        {1'b0, `RST_DIV2}, {1'b0, `RST_DIV1}, {1'b0, `RST_DIV0},
        `RST_POWER_DOWN, `RST_INPUT_SRC, `RST_PIN_AND_SEL
    };
    localparam logic [2:0] SEL_RST = 3'(`RST_OUT_CFG & 8'h07);
    localparam cfg_state_t ST_RST = '{
        regs: REG_RST,
        st: BS_IDLE,
        ph: PH_ADDR,
        rw: 1'b0,
        nack: 1'b0,
        bits: 4'h0,
        sh: 8'h00,
        ptr: 8'h00,
        sda_oe: 1'b0,
        scl_q: 1'b1,
        sda_q: 1'b1,
        mode_eff: pin_mode_t'(2'(`RST_PIN_AND_SEL >> `POS_PIN_MODE)),
        src_eff: src_mode_t'(2'(`RST_INPUT_SRC >> `POS_INPUT_SRC)),
        sel_eff: {`NUM_OUT{SEL_RST}},
        ref_q: 1'b0,
        out: '0,
        oe: '0
    };

    cfg_state_t q; // registered state
    cfg_state_t n; // next state
    logic [`NUM_DIV-1:0] div_out; // divider outputs
    logic [`NUM_DIV-1:0][`DIV_W-1:0] ratios; // divider fields
    logic ref_lvl; // selected reference level
    logic tick; // reference rising edge
    logic pd; // power-down bit
    logic [6:0] my_addr; // live slave address

    // ----------------------------------------
    // register field views
    // ----------------------------------------
    // power-down bit of the stored configuration
    assign pd = q.regs[`OFF_POWER_DOWN - `OFF_PIN_AND_SEL][`POS_POWER_DOWN];

    // select bit only matters for two single-ended inputs
    always_comb begin
        if (q.src_eff == SRC_LVCMOS && q.regs[0][`POS_INPUT_SEL]) begin
            ref_lvl = SECOND_CLOCK_INPUT_I;
        end else begin
            ref_lvl = FIRST_CLOCK_INPUT_I;
        end
    end

    // a powered-down input stage delivers no edges
    assign tick = ref_lvl & ~q.ref_q & ~pd;

    // address bit one follows the pin once its mode is live
    always_comb begin
        my_addr = SLAVE_ADDR;
        if (q.mode_eff == PM_ADDR) begin
            my_addr[1] = SECOND_CONTROL_PIN_I;
        end
    end

    // ----------------------------------------
    // post-dividers
    // ----------------------------------------
    localparam logic [`NUM_DIV-1:0][`DIV_W-1:0] DIV_RST = {
        `RST_DIV5, `RST_DIV4, `RST_DIV3, `RST_DIV2, `RST_DIV1, `RST_DIV0
    };

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_DIV; gi++) begin : g_div
            assign ratios[gi] = q.regs[3 + gi][`DIV_W-1:0];
            post_divider #(
                .RST_RATIO(DIV_RST[gi])
            ) u_div (
                .clk_i(CLK_I),
                .rst_n_i(RST_N_I),
                .ratio_i(ratios[gi]),
                .tick_i(tick),
                .lvl_i(ref_lvl),
                .div_o(div_out[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic scl_rise; // clock edge events
        logic scl_fall;
        logic start_c; // bus conditions
        logic stop_c;
        logic [7:0] rel; // offset relative to first register
        logic mapped; // pointer inside the map
        logic [7:0] rd; // read data
        logic dsel; // divider picked by an output
        logic inv; // output inversion
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        rel = 8'h00;
        mapped = 1'b0;
        rd = 8'h00;
        dsel = 1'b0;
        inv = 1'b0;
        n = q;
        n.scl_q = SCL_I;
        n.sda_q = SDA_I;
        n.ref_q = ref_lvl;
        scl_rise = SCL_I & ~q.scl_q;
        scl_fall = ~SCL_I & q.scl_q;
        start_c = SCL_I & q.scl_q & q.sda_q & ~SDA_I;
        stop_c = SCL_I & q.scl_q & ~q.sda_q & SDA_I;
        rel = q.ptr - `OFF_PIN_AND_SEL;
        mapped = (q.ptr >= `OFF_PIN_AND_SEL) && (q.ptr <= `OFF_LAST);
        rd = mapped ? q.regs[rel[3:0]] : 8'h00;

        // serial slave; registers stay alive in power-down
        if (start_c) begin
            n.st = BS_RX;
            n.ph = PH_ADDR;
            n.bits = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st = BS_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                BS_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                BS_RX: begin
                    // bits arrive on rising clock, byte ends on the fall
                    if (scl_rise && q.bits != 4'h8) begin
                        n.sh = {q.sh[6:0], SDA_I};
                        n.bits = q.bits + 4'h1;
                    end else if (scl_fall && q.bits == 4'h8) begin
                        n.st = BS_ACK;
                        n.sda_oe = 1'b1;
                        unique case (q.ph)
                            PH_ADDR: begin
                                // a foreign address drops off the bus
                                n.rw = q.sh[0];
                                if (q.sh[7:1] != my_addr) begin
                                    n.st = BS_IDLE;
                                    n.sda_oe = 1'b0;
                                end
                            end
                            PH_PTR: begin
                                n.ptr = q.sh;
                            end
                            default: begin
                                // write lands now, so the next byte or
                                // transfer sees the new settings
                                if (mapped) begin
                                    n.regs[rel[3:0]] = q.sh;
                                end
                                n.ptr = q.ptr + 8'h01;
                            end
                        endcase
                    end
                end
                BS_ACK: begin
                    // acknowledge held through the ninth clock
                    if (scl_fall) begin
                        n.bits = 4'h0;
                        if (q.ph == PH_ADDR && q.rw) begin
                            n.st = BS_TX;
                            n.sh = rd;
                            n.sda_oe = ~rd[7];
                            n.ptr = q.ptr + 8'h01;
                        end else begin
                            n.st = BS_RX;
                            n.sda_oe = 1'b0;
                            n.ph = (q.ph == PH_ADDR) ? PH_PTR : PH_DATA;
                        end
                    end
                end
                BS_TX: begin
                    // shift the next bit out on each falling clock
                    if (scl_fall) begin
                        if (q.bits == 4'h7) begin
                            n.st = BS_TXACK;
                            n.sda_oe = 1'b0;
                        end else begin
                            n.sh = {q.sh[6:0], 1'b0};
                            n.sda_oe = ~q.sh[6];
                            n.bits = q.bits + 4'h1;
                        end
                    end
                end
                BS_TXACK: begin
                    // a master nack ends the read
                    if (scl_rise) begin
                        n.nack = SDA_I;
                    end else if (scl_fall) begin
                        n.bits = 4'h0;
                        if (q.nack) begin
                            n.st = BS_IDLE;
                        end else begin
                            n.st = BS_TX;
                            n.sh = rd;
                            n.sda_oe = ~rd[7];
                            n.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                default: begin
                    n.st = BS_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end

        // effective settings follow the freshly written bytes;
        // a reserved code leaves the last valid one in force
        if (pin_mode_t'(n.regs[0][`POS_PIN_MODE +: 2]) != PM_RSVD) begin
            n.mode_eff = pin_mode_t'(n.regs[0][`POS_PIN_MODE +: 2]);
        end
        if (src_mode_t'(n.regs[1][`POS_INPUT_SRC +: 2]) != SRC_RSVD) begin
            n.src_eff = src_mode_t'(n.regs[1][`POS_INPUT_SRC +: 2]);
        end
        for (int i = 0; i < `NUM_OUT; i++) begin
            if (n.regs[9 + i][2:0] <= 3'h5) begin
                n.sel_eff[i] = n.regs[9 + i][2:0];
            end
        end

        // output stage: power-down first, then the pin, then the clock
        for (int i = 0; i < `NUM_OUT; i++) begin
            dsel = div_out[q.sel_eff[i]];
            inv = q.regs[9 + i][`POS_OUT_INV];
            n.out[i] = q.regs[9 + i][`POS_OUT_EN] ? (dsel ^ inv) : 1'b0;
            n.oe[i] = 1'b1;
            if (pd) begin
                n.oe[i] = 1'b0;
            end else if (!SECOND_CONTROL_PIN_I && q.mode_eff == PM_FORCE_LOW) begin
                n.out[i] = inv;
            end else if (!SECOND_CONTROL_PIN_I && q.mode_eff == PM_TRISTATE) begin
                n.oe[i] = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // open drain: the pad only ever pulls low
    assign SDA_O = 1'b0;
    assign SDA_OE_O = q.sda_oe;
    assign CLOCK_OUTPUT_O = q.out;
    assign CLOCK_OUTPUT_OE_O = q.oe;
    assign INPUT_SOURCE_O = q.src_eff;
    assign POWER_DOWN_O = pd;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pd_tristate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        pd |=> (CLOCK_OUTPUT_OE_O == '0))
        else $error("outputs driven in power-down");
    a_force_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!pd && q.mode_eff == PM_FORCE_LOW && !SECOND_CONTROL_PIN_I)
        |=> (CLOCK_OUTPUT_OE_O == '1) && (CLOCK_OUTPUT_O == $past({q.regs[14][6], q.regs[13][6],
        q.regs[12][6], q.regs[11][6], q.regs[10][6], q.regs[9][6]})))
        else $error("outputs not forced inactive");
    a_pin_tristate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!pd && q.mode_eff == PM_TRISTATE && !SECOND_CONTROL_PIN_I) |=> (CLOCK_OUTPUT_OE_O == '0))
        else $error("outputs driven with pin low");
    a_addr_mode_live: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (q.st == BS_RX && q.ph == PH_DATA && q.bits == 4'h8 && !SCL_I && q.scl_q
        && q.ptr == `OFF_PIN_AND_SEL && q.sh[3:2] == 2'b11) |=> (q.mode_eff == PM_ADDR))
        else $error("address mode not live after write");
    a_mode_rsvd_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (q.regs[0][3:2] == 2'b10) |-> (q.mode_eff != PM_RSVD) ##1 $stable(q.mode_eff) || q.regs[0][3:2] != 2'b10)
        else $error("reserved mode changed behaviour");
    a_src_second: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (q.src_eff == SRC_LVCMOS && q.regs[0][4]) |=> (q.ref_q == $past(SECOND_CLOCK_INPUT_I)))
        else $error("second input not routed");
    a_sel_ignored: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (q.src_eff != SRC_LVCMOS) |=> (q.ref_q == $past(FIRST_CLOCK_INPUT_I)))
        else $error("select bit not ignored");
    a_out_sel_valid: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (q.sel_eff[0] <= 3'h5) && (q.regs[9][2:0] > 3'h5 || q.sel_eff[0] == q.regs[9][2:0]))
        else $error("output select wrong");
    a_pd_no_ticks: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        pd |-> !tick ##1 (q.regs == $past(q.regs) || q.st == BS_ACK))
        else $error("edges or registers lost in power-down");

endmodule // clk_cfg_top

`default_nettype wire

// *** hdl/post_divider.sv ***
// one output post-divider clocked by reference edge ticks
`timescale 1ns/100ps
`default_nettype none
`include "clk_cfg_map.svh"

module post_divider
    import clk_cfg_pkg::*;
#(
    parameter logic [`DIV_W-1:0] RST_RATIO = `RST_DIV0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`DIV_W-1:0] ratio_i,
    input wire logic tick_i,
    input wire logic lvl_i,
    output logic div_o
);

    div_state_t q; // registered state
    div_state_t n; // next state

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;
        // a zero ratio is not allowed, so the last valid one stays
        if (ratio_i != '0) begin
            n.ratio = ratio_i;
        end
        // a shrunk ratio must not leave the counter past its end
        if (q.cnt >= n.ratio) begin
            n.cnt = '0;
        end else if (tick_i) begin
            n.cnt = (q.cnt == n.ratio - 7'h01) ? '0 : q.cnt + 7'h01;
        end
        // divide by one passes the reference level straight on
        if (n.ratio == 7'h01) begin
            n.out = lvl_i;
        end else begin
            n.out = (n.cnt < (n.ratio >> 1));
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{ratio: RST_RATIO, cnt: '0, out: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign div_o = q.out;

    a_zero_ratio_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ratio_i == '0) |=> (q.ratio == $past(q.ratio)))
        else $error("zero ratio changed the divider");
    a_count_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ratio_i != '0) |=> (q.ratio == $past(ratio_i)) && (q.cnt < q.ratio))
        else $error("divider ratio or count wrong");

endmodule // post_divider

`default_nettype wire

// *** include/clk_cfg_map.svh ***
// register offsets, field positions, reset values and counts of the clock configuration block
`ifndef CLK_CFG_MAP_SVH
`define CLK_CFG_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_PIN_AND_SEL 8'h0A
`define OFF_INPUT_SRC 8'h0B
`define OFF_POWER_DOWN 8'h0C
`define OFF_POST_DIV0 8'h0D
`define OFF_OUT_CFG0 8'h13
`define OFF_LAST 8'h18

// ----------------------------------------
// counts and widths
// ----------------------------------------
`define NUM_REGS 15
`define NUM_DIV 6
`define NUM_OUT 6
`define DIV_W 7

// ----------------------------------------
// field positions
// ----------------------------------------
`define POS_PIN_MODE 2
`define POS_INPUT_SEL 4
`define POS_INPUT_SRC 6
`define POS_POWER_DOWN 6
`define POS_OUT_EN 3
`define POS_OUT_INV 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PIN_AND_SEL 8'h00
`define RST_INPUT_SRC 8'h00
`define RST_POWER_DOWN 8'h00
`define RST_DIV0 7'h0A
`define RST_DIV1 7'h14
`define RST_DIV2 7'h08
`define RST_DIV3 7'h09
`define RST_DIV4 7'h20
`define RST_DIV5 7'h04
`define RST_OUT_CFG 8'h3A
// arbitrary neutral slave address
`define SLAVE_ADDR_DEFAULT 7'h55

`endif

// *** include/clk_cfg_pkg.sv ***
// types of the clock configuration block
package clk_cfg_pkg;
`include "clk_cfg_map.svh"

    // function of the second control pin
    typedef enum logic [1:0] {
        PM_FORCE_LOW = 2'b00,
        PM_TRISTATE = 2'b01,
        PM_RSVD = 2'b10,
        PM_ADDR = 2'b11
    } pin_mode_t;

    // input signal source
    typedef enum logic [1:0] {
        SRC_XTAL = 2'b00,
        SRC_LVCMOS = 2'b01,
        SRC_DIFF = 2'b10,
        SRC_RSVD = 2'b11
    } src_mode_t;

    // serial slave states
    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_RX = 3'b001,
        BS_ACK = 3'b010,
        BS_TX = 3'b011,
        BS_TXACK = 3'b100
    } bus_st_t;

    // which byte of a transfer is being received
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_PTR = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

    // whole state of the configuration block
    typedef struct packed {
        logic [`NUM_REGS-1:0][7:0] regs;
        bus_st_t st;
        phase_t ph;
        logic rw;
        logic nack;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
        pin_mode_t mode_eff;
        src_mode_t src_eff;
        logic [`NUM_OUT-1:0][2:0] sel_eff;
        logic ref_q;
        logic [`NUM_OUT-1:0] out;
        logic [`NUM_OUT-1:0] oe;
    } cfg_state_t;

    // whole state of one post-divider
    typedef struct packed {
        logic [`DIV_W-1:0] ratio;
        logic [`DIV_W-1:0] cnt;
        logic out;
    } div_state_t;

endpackage

// *** verification/smbus_host.sv ***
// serial bus host model that programs the configuration bytes
`timescale 1ns/100ps
`default_nettype none

module smbus_host (
    input wire logic clk_i,
    input wire logic dev_sda_oe_i,
    output var logic scl_o,
    output wire logic sda_o
);
    // ----------------------------------------
    // open-drain data wire
    // ----------------------------------------
    logic sda_drv_r = 1'b1; // host drive, 1 = released
    initial scl_o = 1'b1;
    // pull-up: low whenever either party pulls
    assign sda_o = sda_drv_r & ~dev_sda_oe_i;

    // ----------------------------------------
    // bus phases
    // ----------------------------------------
    // each line state is held four cycles, so both phases stay above two cycles
    task automatic line(input logic scl, input logic sda);
        @(posedge clk_i);
        scl_o <= scl;
        sda_drv_r <= sda;
        repeat (3) @(posedge clk_i);
    endtask
    // data changes only once the clock is low, never on the same edge as its fall
    task automatic bit_io(input logic b, output logic r);
        line(1'b0, sda_drv_r);
        line(1'b0, b);
        line(1'b1, b);
        r = sda_o;
    endtask
    // byte msb first, then the acknowledge bit; ack_o high when the wire was low
    task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx, output logic ack_o);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(rel, a);
        ack_o = ~a;
    endtask
    // start and repeated start: data falls with the clock high
    task automatic start();
        line(1'b0, sda_drv_r);
        line(1'b0, 1'b1);
        line(1'b1, 1'b1);
        line(1'b1, 1'b0);
    endtask
    // stop: data rises with the clock high
    task automatic stop();
        line(1'b0, sda_drv_r);
        line(1'b0, 1'b0);
        line(1'b1, 1'b0);
        line(1'b1, 1'b1);
    endtask

    // ----------------------------------------
    // transfers
    // ----------------------------------------
    // address, pointer, then data bytes to successive places
    task automatic write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$], output logic ok);
        logic [7:0] rx;
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, rx, ok);
        xfer(p, 1'b1, rx, k);
        foreach (d[i]) begin
            xfer(d[i], 1'b1, rx, k);
        end
        stop();
    endtask
    // pointer write, repeated start, one byte read and left unacknowledged
    task automatic read(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, d, ok);
        xfer(p, 1'b1, d, k);
        start();
        xfer({a, 1'b1}, 1'b1, d, k);
        xfer(8'hFF, 1'b1, d, k);
        stop();
    endtask
endmodule // smbus_host
`default_nettype wire

// *** verification/tb_clock_input_output_config.sv ***
// self-checking bench of the clock configuration block
`timescale 1ns/100ps
`default_nettype none
`include "clk_cfg_map.svh"

module tb_clock_input_output_config;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin = 1'b1; // second control pin
    logic ref0 = 1'b0; // first input, period 8 cycles
    logic ref1 = 1'b0; // second input, period 12 cycles
    logic [1:0] c0 = 2'h0;
    logic [2:0] c1 = 3'h0;
    wire logic scl;
    wire logic sda;
    wire logic sda_oe;
    wire logic sda_pull;
    wire logic [5:0] clk_out;
    wire logic [5:0] clk_oe;
    wire logic [1:0] src;
    wire logic pd;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [6:0] addr = 7'h55;
    logic [7:0] d;
    logic ok;
    logic [15:0] p;
    logic [7:0] rst_tab [15] = '{8'h00, 8'h00, 8'h00, 8'h0A, 8'h14, 8'h08, 8'h09, 8'h20, 8'h04,
                                 8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A};
    // select code k: divider ratio times reference period
    logic [15:0] per_tab [6] = '{16'd80, 16'd160, 16'd64, 16'd72, 16'd256, 16'd32};
    // source byte, expected code, expected period
    logic [31:0] src_tab [4] = '{32'h4001_0060, 32'h8002_0040, 32'h0000_0040, 32'hC000_0040};
    // pointer, value, expected period on output zero
    logic [31:0] div_tab [6] = '{32'h0D03_0040, 32'h1338_0018, 32'h133E_0018, 32'h0D00_0018,
                                 32'h0D01_0008, 32'h0D7F_03F8};

    always #2.5 clk = ~clk;

    // ----------------------------------------
    // reference inputs and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        c0 <= c0 + 2'h1;
        if (c0 == 2'h3) begin
            ref0 <= ~ref0;
        end
        c1 <= (c1 == 3'h5) ? 3'h0 : c1 + 3'h1;
        if (c1 == 3'h5) begin
            ref1 <= ~ref1;
        end
        cyc <= cyc + 1;
        // well above the expected run of some twenty-five thousand cycles
        if (cyc == 80000) begin
            fail_count++;
            give_verdict();
        end
    end

    clk_cfg_top dut (
        .CLK_I(clk),
        .RST_N_I(rst_n),
        .SCL_I(scl),
        .SDA_I(sda),
        .SDA_O(sda_pull),
        .SDA_OE_O(sda_oe),
        .SECOND_CONTROL_PIN_I(pin),
        .FIRST_CLOCK_INPUT_I(ref0),
        .SECOND_CLOCK_INPUT_I(ref1),
        .CLOCK_OUTPUT_O(clk_out),
        .CLOCK_OUTPUT_OE_O(clk_oe),
        .INPUT_SOURCE_O(src),
        .POWER_DOWN_O(pd)
    );

    smbus_host host (
        .clk_i(clk),
        .dev_sda_oe_i(sda_oe),
        .scl_o(scl),
        .sda_o(sda)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] v[$]);
        host.write(addr, ptr, v, ok);
    endtask
    task automatic rd(input logic [7:0] ptr);
        host.read(addr, ptr, d, ok);
    endtask
    // second rising-edge interval, so a ratio change has settled first
    task automatic period(input int b);
        int c;
        int t0;
        int e;
        logic prev;
        c = 0;
        t0 = 0;
        e = 0;
        prev = clk_out[b];
        while (e < 3 && c < 4000) begin
            @(posedge clk);
            c++;
            if (prev === 1'b0 && clk_out[b] === 1'b1) begin
                e++;
                if (e == 2) begin
                    t0 = c;
                end
            end
            prev = clk_out[b];
        end
        p = 16'(c - t0);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 15; i++) begin
            rd(8'h0A + 8'(i));
            chk("reset value", rst_tab[i], d);
        end
        rd(8'h20);
        chk("unmapped read", 16'h0000, d);
        chk("source at reset", 16'h0000, 16'(src));
        chk("data pull value", 16'h0000, 16'(sda_pull));
        for (int k = 0; k < 6; k++) begin
            wr(8'h13, '{8'h38 | 8'(k)});
            period(0);
            chk("select period", per_tab[k], p);
        end
        // force-low with output one inverted, then tri-state mode
        wr(8'h14, '{8'h7A});
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk("forced levels", 16'h0002, 16'(clk_out));
        chk("forced enables", 16'h003F, 16'(clk_oe));
        wr(8'h0A, '{8'h04});
        chk("tri-state enables", 16'h0000, 16'(clk_oe));
        wr(8'h0A, '{8'h08});
        chk("reserved mode enables", 16'h0000, 16'(clk_oe));
        // power down while force-low is active: tri-state wins, registers kept
        wr(8'h0A, '{8'h00});
        wr(8'h0C, '{8'h40});
        chk("power down enables", 16'h0000, 16'(clk_oe));
        chk("power down flag", 16'h0001, 16'(pd));
        rd(8'h14);
        chk("kept in power down", 16'h007A, 16'(d));
        wr(8'h0C, '{8'h00});
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        chk("enables after power up", 16'h003F, 16'(clk_oe));
        // each source code with the select bit set; reserved code keeps crystal
        wr(8'h13, '{8'h3A});
        wr(8'h0A, '{8'h10});
        for (int k = 0; k < 4; k++) begin
            wr(8'h0B, '{src_tab[k][31:24]});
            period(0);
            chk("source period", src_tab[k][15:0], p);
            chk("source code", 16'(src_tab[k][23:16]), 16'(src));
        end
        wr(8'h0B, '{8'h40});
        wr(8'h0A, '{8'h00});
        period(0);
        chk("first input period", 16'd64, p);
        for (int k = 0; k < 6; k++) begin
            wr(div_tab[k][31:24], '{div_tab[k][23:16]});
            period(0);
            chk("divider period", div_tab[k][15:0], p);
        end
        // pin address: mode set inside a block write before any pin addressing
        wr(8'h0A, '{8'h0C, 8'h00});
        rd(8'h0B);
        chk("old address ack", 16'h0000, 16'(ok));
        addr = 7'h57;
        rd(8'h0B);
        chk("pin address ack", 16'h0001, 16'(ok));
        pin <= 1'b0;
        addr = 7'h55;
        rd(8'h0A);
        chk("pin low address", 16'h000C, 16'(d));
        chk("no force in address mode", 16'h003F, 16'(clk_oe));
        give_verdict();
    end
endmodule // tb_clock_input_output_config
`default_nettype wire
